// ==== verilog/irpct_top.sv ====
// eight- and sixteen-bit pulse counter/timers with register port
`timescale 1ns/1ns
module irpct_top
  import irpct_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata_q,
  // ordinary port output values
  input  wire logic       port3_bit4_port_val,
  input  wire logic       port3_bit6_port_val,
  // receiver pins
  input  wire logic       port3_bit1_pin,
  input  wire logic       port2_bit0_pin,
  // emitter pins
  output logic            port3_bit4_pin_q,
  output logic            port3_bit6_pin_q,
  // interrupt requests
  output logic            narrow_timer_irq_q,
  output logic            capture_irq_q
);
  import irpct_pkg::*;

  // narrow_timer_control fields
  logic       t8_en_q;
  logic       t8_single_q;
  logic       t8_to_q;
  logic [1:0] t8_clk_q;
  logic       cap_ie_q;
  logic       cnt_ie_q;
  logic       route_q;
  // shared_timer_control
  logic [7:2] shr_q;
  logic [1:0] shr_lo_q;
  // wide_timer_control fields
  logic       t16_en_q;
  logic       t16_single_q;
  logic       t16_to_q;
  // reloads and captures
  logic [7:0]  nrld_q;
  logic [15:0] wrld_q;
  logic [7:0]  cap_lo_q;
  logic [7:0]  cap_hi_q;
  // outputs and prescaler
  logic        narrow_timer_output_q;
  logic        wide_timer_output_q;
  logic [2:0]  pre_q;

  logic        wr_ntc;
  logic        wr_shr;
  logic        wr_wtc;
  logic        demod;
  logic        pp;
  logic [1:0]  sub;
  logic        t8_tick;
  logic [7:0]  t8_cnt;
  logic        t8_zero;
  logic        t8_tc;
  logic        t8_start;
  logic        t8_stop;
  logic        t8_load;
  logic [15:0] t16_cnt;
  logic        t16_zero;
  logic        t16_tc;
  logic        t16_start;
  logic        t16_stop;
  logic        t16_load;
  logic        demod_in;
  logic        rise;
  logic        fall;
  logic        cap_evt;
  logic        comb_out;
  logic [7:0]  rd_mux;

  assign wr_ntc = wr && addr == ADDR_NTC;
  assign wr_shr = wr && addr == ADDR_SHR;
  assign wr_wtc = wr && addr == ADDR_WTC;
  assign demod  = shr_q[BIT_MODE];
  assign sub    = shr_q[3:2];
  assign pp     = !demod && sub == SUB_PP;

  // free-running prescaler; enabling mid-period gives a short first tick
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_q <= 3'h0;
    else if (ce)
      pre_q <= pre_q + 3'h1;
  end

  always_comb
  begin
    case (t8_clk_q)
      2'h0:    t8_tick = 1'b1;
      2'h1:    t8_tick = pre_q[0];
      2'h2:    t8_tick = &pre_q[1:0];
      default: t8_tick = &pre_q;
    endcase
  end

  // narrow timer sequencing
  assign t8_tc    = t8_en_q && t8_tick && t8_zero;
  assign t8_start = (wr_ntc && wdata[BIT_EN] && !t8_en_q)
                    || (pp && t16_tc);
  assign t8_stop  = (wr_ntc && !wdata[BIT_EN])
                    || (t8_tc && !demod && (t8_single_q || pp));
  assign cap_evt  = demod && t8_en_q && (rise || fall);
  assign t8_load  = t8_start || (t8_tc && !t8_stop) || cap_evt;

  irpct_down_counter #(
    .W (8)
  ) u_t8 (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (t8_load),
    .load_val ((demod || cap_evt) ? T8_MAX : nrld_q),
    .dec      (t8_en_q && t8_tick && !t8_zero),
    .cnt_q    (t8_cnt),
    .zero     (t8_zero)
  );

  // wide timer sequencing, ticks on every enabled cycle
  assign t16_tc    = t16_en_q && t16_zero;
  assign t16_start = (wr_wtc && wdata[BIT_EN] && !t16_en_q)
                     || (pp && t8_tc);
  assign t16_stop  = (wr_wtc && !wdata[BIT_EN])
                     || (t16_tc && !demod && (t16_single_q || pp));
  assign t16_load  = t16_start || (t16_tc && !t16_stop)
                     || (demod && t16_en_q && !t16_single_q
                         && (rise || fall));

  irpct_down_counter #(
    .W (16)
  ) u_t16 (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (t16_load),
    .load_val (demod ? T16_MAX : wrld_q),
    .dec      (t16_en_q && !t16_zero),
    .cnt_q    (t16_cnt),
    .zero     (t16_zero)
  );

  // demodulator input select and edge detection
  assign demod_in = shr_q[BIT_SEL] ? port2_bit0_pin : port3_bit1_pin;

  irpct_edge_det u_edge (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce && demod),
    .filt_sel (shr_q[3:2]),
    .edge_sel (shr_q[5:4]),
    .din      (demod_in),
    .rise_q   (rise),
    .fall_q   (fall)
  );

  // narrow_timer_control register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t8_en_q     <= 1'b0;
      t8_single_q <= 1'b0;
      t8_clk_q    <= 2'h0;
      cap_ie_q    <= 1'b0;
      cnt_ie_q    <= 1'b0;
      route_q     <= 1'b0;
    end
    else if (ce)
    begin
      if (t8_start)
        t8_en_q <= 1'b1;
      else if (t8_stop)
        t8_en_q <= 1'b0;
      if (wr_ntc)
      begin
        t8_single_q <= wdata[BIT_SINGLE];
        t8_clk_q    <= wdata[BIT_CLK_HI:BIT_CLK_LO];
        cap_ie_q    <= wdata[BIT_CAP_IE];
        cnt_ie_q    <= wdata[BIT_CNT_IE];
        route_q     <= wdata[BIT_ROUTE];
      end
    end
  end

  // timeout flags: a new timeout beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t8_to_q  <= 1'b0;
      t16_to_q <= 1'b0;
    end
    else if (ce)
    begin
      t8_to_q  <= t8_tc
                  || (t8_to_q && !(wr_ntc && wdata[BIT_TO]));
      t16_to_q <= t16_tc
                  || (t16_to_q && !(wr_wtc && wdata[BIT_TO]));
    end
  end

  // wide_timer_control register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t16_en_q     <= 1'b0;
      t16_single_q <= 1'b0;
    end
    else if (ce)
    begin
      if (t16_start)
        t16_en_q <= 1'b1;
      else if (t16_stop)
        t16_en_q <= 1'b0;
      if (wr_wtc)
        t16_single_q <= wdata[BIT_SINGLE];
    end
  end

  // shared_timer_control; low bits are edge flags in demodulation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shr_q    <= SHR_RST[7:2];
      shr_lo_q <= SHR_RST[1:0];
    end
    else if (ce)
    begin
      if (wr_shr)
        shr_q <= wdata[7:2];
      if (demod)
      begin
        shr_lo_q[BIT_INIT8]  <= rise || (shr_lo_q[BIT_INIT8]
                                && !(wr_shr && wdata[BIT_INIT8]));
        shr_lo_q[BIT_INIT16] <= fall || (shr_lo_q[BIT_INIT16]
                                && !(wr_shr && wdata[BIT_INIT16]));
      end
      else if (wr_shr)
        shr_lo_q <= wdata[1:0];
    end
  end

  // reload values and edge captures
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nrld_q   <= NRLD_RST;
      wrld_q   <= WRLD_RST;
      cap_lo_q <= 8'h00;
      cap_hi_q <= 8'h00;
    end
    else if (ce)
    begin
      if (wr && addr == ADDR_NRLD)
        nrld_q <= wdata;
      if (wr && addr == ADDR_WRLO)
        wrld_q[7:0] <= wdata;
      if (wr && addr == ADDR_WRHI)
        wrld_q[15:8] <= wdata;
      // elapsed ticks since last reload to the maximum
      if (cap_evt && fall)
        cap_lo_q <= ~t8_cnt;
      if (cap_evt && rise)
        cap_hi_q <= ~t8_cnt;
    end
  end

  // timer output levels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      narrow_timer_output_q  <= 1'b1;
      wide_timer_output_q <= 1'b1;
    end
    else if (ce)
    begin
      if (t8_start)
        narrow_timer_output_q <= shr_lo_q[BIT_INIT8];
      else if (!t8_en_q)
        narrow_timer_output_q <= ~shr_lo_q[BIT_INIT8];
      else if (t8_tc)
        narrow_timer_output_q <= ~narrow_timer_output_q;
      if (sub == SUB_LOW)
        wide_timer_output_q <= 1'b0;
      else if (sub == SUB_HIGH)
        wide_timer_output_q <= 1'b1;
      else if (t16_start)
        wide_timer_output_q <= shr_lo_q[BIT_INIT16];
      else if (!t16_en_q)
        wide_timer_output_q <= ~shr_lo_q[BIT_INIT16];
      else if (t16_tc)
        wide_timer_output_q <= ~wide_timer_output_q;
    end
  end

  always_comb
  begin
    case (shr_q[5:4])
      LOGIC_AND: comb_out = narrow_timer_output_q & wide_timer_output_q;
      LOGIC_OR:  comb_out = narrow_timer_output_q | wide_timer_output_q;
      LOGIC_NOR: comb_out = ~(narrow_timer_output_q | wide_timer_output_q);
      default:   comb_out = ~(narrow_timer_output_q & wide_timer_output_q);
    endcase
  end

  // pins and interrupt requests, all registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port3_bit4_pin_q   <= 1'b0;
      port3_bit6_pin_q   <= 1'b0;
      narrow_timer_irq_q <= 1'b0;
      capture_irq_q      <= 1'b0;
    end
    else if (ce)
    begin
      port3_bit4_pin_q   <= route_q ? narrow_timer_output_q : port3_bit4_port_val;
      port3_bit6_pin_q   <= (!demod && shr_q[BIT_SEL]) ? comb_out
                            : port3_bit6_port_val;
      narrow_timer_irq_q <= t8_tc && cnt_ie_q;
      capture_irq_q      <= cap_evt && cap_ie_q;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    case (addr)
      ADDR_NTC:   rd_mux = {t8_en_q, t8_single_q, t8_to_q, t8_clk_q,
                            cap_ie_q, cnt_ie_q, route_q};
      ADDR_SHR:   rd_mux = {shr_q, shr_lo_q};
      ADDR_WTC:   rd_mux = {t16_en_q, t16_single_q, t16_to_q, 5'h00};
      ADDR_NRLD:  rd_mux = nrld_q;
      ADDR_WRLO:  rd_mux = wrld_q[7:0];
      ADDR_WRHI:  rd_mux = wrld_q[15:8];
      ADDR_CAPLO: rd_mux = cap_lo_q;
      ADDR_CAPHI: rd_mux = cap_hi_q;
      default:    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (ce)
      rdata_q <= rd ? rd_mux : 8'h00;
  end
endmodule

// ==== verilog/irpct_pkg.sv ====
// constants, offsets and field positions of the pulse counter/timer pair
package irpct_pkg;
  localparam logic [7:0] ADDR_NTC   = 8'h00;
  localparam logic [7:0] ADDR_SHR   = 8'h01;
  localparam logic [7:0] ADDR_WTC   = 8'h02;
  localparam logic [7:0] ADDR_NRLD  = 8'h03;
  localparam logic [7:0] ADDR_WRLO  = 8'h04;
  localparam logic [7:0] ADDR_WRHI  = 8'h05;
  localparam logic [7:0] ADDR_CAPLO = 8'h06;
  localparam logic [7:0] ADDR_CAPHI = 8'h07;
  localparam int BIT_EN     = 7;
  localparam int BIT_SINGLE = 6;
  localparam int BIT_TO     = 5;
  localparam int BIT_CLK_HI = 4;
  localparam int BIT_CLK_LO = 3;
  localparam int BIT_CAP_IE = 2;
  localparam int BIT_CNT_IE = 1;
  localparam int BIT_ROUTE  = 0;
  localparam int BIT_MODE   = 7;
  localparam int BIT_SEL    = 6;
  localparam int BIT_INIT8  = 1;
  localparam int BIT_INIT16 = 0;
  localparam logic [7:0]  SHR_RST   = 8'h00;
  localparam logic [7:0]  NRLD_RST  = 8'hFF;
  localparam logic [15:0] WRLD_RST  = 16'hFFFF;
  localparam logic [7:0]  T8_MAX    = 8'hFF;
  localparam logic [15:0] T16_MAX   = 16'hFFFF;
  localparam logic [1:0]  LOGIC_AND  = 2'h0;
  localparam logic [1:0]  LOGIC_OR   = 2'h1;
  localparam logic [1:0]  LOGIC_NOR  = 2'h2;
  localparam logic [1:0]  SUB_PP     = 2'h1;
  localparam logic [1:0]  SUB_LOW    = 2'h2;
  localparam logic [1:0]  SUB_HIGH   = 2'h3;
  localparam logic [1:0]  EDGE_FALL  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_BOTH  = 2'h2;
  localparam logic [1:0]  FILT_4     = 2'h1;
  localparam logic [1:0]  FILT_8     = 2'h2;
  localparam logic [3:0]  FILT_4_CYC = 4'h4;
  localparam logic [3:0]  FILT_8_CYC = 4'h8;
endpackage

// ==== verilog/irpct_down_counter.sv ====
// loadable down counter shared by both timers
`timescale 1ns/1ns
module irpct_down_counter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  // state
  output logic      [W-1:0] cnt_q,
  output logic              zero
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (ce)
    begin
      if (load)
        cnt_q <= load_val;
      else if (dec)
        cnt_q <= cnt_q - W'(1);
    end
  end

  assign zero = (cnt_q == '0);
endmodule

// ==== verilog/irpct_edge_det.sv ====
// glitch filter and edge detector for the demodulator input
`timescale 1ns/1ns
module irpct_edge_det
  import irpct_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // setup
  input  wire logic [1:0] filt_sel,
  input  wire logic [1:0] edge_sel,
  // input and events
  input  wire logic       din,
  output logic            rise_q,
  output logic            fall_q
);
  logic       stable_q;
  logic       prev_q;
  logic [3:0] run_q;
  logic [3:0] need;
  logic       filt_on;

  assign filt_on = (filt_sel == FILT_4) || (filt_sel == FILT_8);
  assign need    = (filt_sel == FILT_4) ? FILT_4_CYC : FILT_8_CYC;

  // reserved filter code behaves as no filter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // receiver idles high; a low seed would fake an edge on mode entry
      stable_q <= 1'b1;
      run_q    <= 4'h0;
    end
    else if (ce)
    begin
      if (!filt_on || din == stable_q)
      begin
        run_q <= 4'h0;
        if (!filt_on)
          stable_q <= din;
      end
      else if (run_q == need - 4'h1)
      begin
        stable_q <= din;
        run_q    <= 4'h0;
      end
      else
        run_q <= run_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 1'b1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else if (ce)
    begin
      prev_q <= stable_q;
      rise_q <= stable_q & ~prev_q
                & (edge_sel == EDGE_RISE || edge_sel == EDGE_BOTH);
      fall_q <= ~stable_q & prev_q
                & (edge_sel == EDGE_FALL || edge_sel == EDGE_BOTH);
    end
  end
endmodule

// ==== testbench/irpct_ir_partner.sv ====
// infrared receiver stand-in driving the demodulator input pins
`timescale 1ns/1ns
module irpct_ir_partner (
  // clock
  input  wire logic clk,
  // commands from the bench
  input  wire logic level,
  input  wire logic alt,
  input  wire logic slow,
  // receiver pins
  output logic      port3_bit1_pin,
  output logic      port2_bit0_pin
);
  logic [3:0] dly_q = 4'hF;
  logic       junk_q = 1'b0;
  logic       sent;
  always_ff @(posedge clk)
  begin
    dly_q  <= {dly_q[2:0], level};
    junk_q <= ~junk_q;
  end
  // slow receiver answers four cycles late
  assign sent = slow ? dly_q[3] : level;
  // unused pin carries noise so a wrong input select shows up as edges
  assign port3_bit1_pin = alt ? junk_q : sent;
  assign port2_bit0_pin = alt ? sent : junk_q;
endmodule

// ==== testbench/irpct_top_chk.sv ====
// port assertions for the pulse counter/timer pair
`timescale 1ns/1ns
module irpct_top_chk
  import irpct_pkg::*;
(
  // clock, reset, enable
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata_q,
  // pins and requests
  input wire logic       port3_bit4_port_val,
  input wire logic       port3_bit6_port_val,
  input wire logic       port3_bit4_pin_q,
  input wire logic       port3_bit6_pin_q,
  input wire logic       narrow_timer_irq_q,
  input wire logic       capture_irq_q
);
  logic [7:0] shr_q;
  logic       shr_ok_q;
  logic [2:0] ntc_q;
  // flags make the shared shadow stale once demodulation was entered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shr_q    <= SHR_RST;
      shr_ok_q <= 1'b1;
      ntc_q    <= 3'h0;
    end
    else if (ce && wr && addr == ADDR_SHR)
    begin
      shr_q    <= wdata;
      shr_ok_q <= !shr_q[BIT_MODE];
    end
    else if (ce && wr && addr == ADDR_NTC)
      ntc_q <= wdata[2:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_reset_quiet;
    $rose(rst_n) |-> rdata_q == 8'h00 && !narrow_timer_irq_q && !capture_irq_q
      && !port3_bit4_pin_q && !port3_bit6_pin_q;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_route_port;
    ce && !ntc_q[BIT_ROUTE] |=> port3_bit4_pin_q == $past(port3_bit4_port_val);
  endproperty
  a_route_port: assert property (p_route_port) else $error("pin4 not port value");
  property p_sel_port;
    ce && !(!shr_q[BIT_MODE] && shr_q[BIT_SEL]) |=> port3_bit6_pin_q == $past(port3_bit6_port_val);
  endproperty
  a_sel_port: assert property (p_sel_port) else $error("pin6 not port value");
  property p_nirq_pulse;
    narrow_timer_irq_q |=> !narrow_timer_irq_q;
  endproperty
  a_nirq_pulse: assert property (p_nirq_pulse) else $error("count request too long");
  property p_nirq_ie;
    narrow_timer_irq_q |-> ntc_q[BIT_CNT_IE];
  endproperty
  a_nirq_ie: assert property (p_nirq_ie) else $error("count request while masked");
  property p_cirq_ie;
    capture_irq_q |-> ntc_q[BIT_CAP_IE];
  endproperty
  a_cirq_ie: assert property (p_cirq_ie) else $error("capture request while masked");
  property p_cirq_mode;
    capture_irq_q |-> shr_q[BIT_MODE];
  endproperty
  a_cirq_mode: assert property (p_cirq_mode) else $error("capture in transmit mode");
  property p_shr_read;
    rd && addr == ADDR_SHR && shr_ok_q && !shr_q[BIT_MODE] |=> rdata_q == shr_q;
  endproperty
  a_shr_read: assert property (p_shr_read) else $error("shared readback wrong");
  property p_wtc_read;
    rd && addr == ADDR_WTC |=> rdata_q[4:0] == 5'h00;
  endproperty
  a_wtc_read: assert property (p_wtc_read) else $error("wide low bits not zero");
endmodule
bind irpct_top irpct_top_chk irpct_top_chk_inst (.clk, .rst_n, .ce, .addr, .wdata, .wr, .rd,
  .rdata_q, .port3_bit4_port_val, .port3_bit6_port_val, .port3_bit4_pin_q, .port3_bit6_pin_q,
  .narrow_timer_irq_q, .capture_irq_q);

// ==== testbench/test_irpct_top.sv ====
// self-checking bench for the pulse counter/timer pair
`timescale 1ns/1ns
module test_irpct_top;
  import irpct_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       port3_bit4_port_val = 1'b0;
  logic       port3_bit6_port_val = 1'b1;
  logic       rx_level = 1'b1;
  logic       rx_alt = 1'b0;
  logic       rx_slow = 1'b0;
  logic       port3_bit1_pin;
  logic       port2_bit0_pin;
  logic [7:0] rdata_q;
  logic       port3_bit4_pin_q;
  logic       port3_bit6_pin_q;
  logic       narrow_timer_irq_q;
  logic       capture_irq_q;
  int         mismatches = 0;
  int         comparisons = 0;
  always #2 clk = ~clk;
  always @(posedge clk) port3_bit6_port_val <= ~port3_bit6_port_val;
  irpct_top irpct_top_inst (.clk, .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata_q,
    .port3_bit4_port_val, .port3_bit6_port_val, .port3_bit1_pin, .port2_bit0_pin,
    .port3_bit4_pin_q, .port3_bit6_pin_q, .narrow_timer_irq_q, .capture_irq_q);
  irpct_ir_partner irpct_ir_partner_inst (.clk, .level(rx_level), .alt(rx_alt),
    .slow(rx_slow), .port3_bit1_pin, .port2_bit0_pin);
  task automatic fail(input string msg);
    mismatches++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
      fail($sformatf("byte %h expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
      fail($sformatf("bit %b expected %b", got, exp));
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rx(input logic lv);
    @(posedge clk);
    rx_level <= lv;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata_q;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(a, v);
    chk_byte(v, exp);
  endtask
  task automatic wait_pulse(input logic cap, input int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      #1;
      if ((cap ? capture_irq_q : narrow_timer_irq_q) === 1'b1)
        break;
    end
    if (n == lim)
    begin
      fail("pulse wait ran out");
      end_of_test();
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] a [7] = '{ADDR_NTC, ADDR_SHR, ADDR_WTC, ADDR_NRLD, ADDR_CAPLO, ADDR_CAPHI, 8'h08};
    for (int i = 0; i < 7; i++)
      rd_chk(a[i], (a[i] == ADDR_NRLD) ? NRLD_RST : 8'h00);
  endtask
  task automatic t_narrow;
    wr_reg(ADDR_NTC, 8'h20);
    wr_reg(ADDR_NRLD, 8'h04);
    wr_reg(ADDR_NTC, 8'hC2);
    wait_pulse(1'b0, 40);
    rd_chk(ADDR_NTC, 8'h62);
    wr_reg(ADDR_NTC, 8'h62);
    rd_chk(ADDR_NTC, 8'h42);
    // divide by two, so the first tick may come early
    wr_reg(ADDR_NRLD, 8'h20);
    wr_reg(ADDR_NTC, 8'h8A);
    wait_pulse(1'b0, 80);
    wait_pulse(1'b0, 80);
    rd_chk(ADDR_NTC, 8'hAA);
    wr_reg(ADDR_NTC, 8'h20);
    rd_chk(ADDR_NTC, 8'h00);
  endtask
  task automatic t_route;
    wr_reg(ADDR_NTC, 8'h01);
    cycles(3);
    chk_bit(port3_bit4_pin_q, 1'b1);
    wr_reg(ADDR_SHR, 8'h02);
    cycles(3);
    chk_bit(port3_bit4_pin_q, 1'b0);
    wr_reg(ADDR_NRLD, 8'hFF);
    wr_reg(ADDR_NTC, 8'h81);
    cycles(3);
    chk_bit(port3_bit4_pin_q, 1'b1);
    wr_reg(ADDR_NTC, 8'h00);
    wr_reg(ADDR_SHR, 8'h00);
    cycles(3);
    chk_bit(port3_bit4_pin_q, 1'b0);
  endtask
  task automatic t_combine;
    logic [1:0] lg;
    logic [1:0] sub;
    logic       w;
    logic       e;
    // both timers idle: narrow output sits at one, wide at its forced or idle level
    port3_bit4_port_val <= 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      lg  = i[4:3];
      sub = i[2:1];
      w   = sub[1] ? sub[0] : ~i[0];
      e   = (lg == LOGIC_AND) ? w : (lg == LOGIC_OR) ? 1'b1 : (lg == LOGIC_NOR) ? 1'b0 : ~w;
      wr_reg(ADDR_SHR, {2'b01, lg, sub, 1'b0, i[0]});
      cycles(3);
      chk_bit(port3_bit6_pin_q, e);
    end
    wr_reg(ADDR_SHR, SHR_RST);
  endtask
  task automatic t_wide;
    logic [7:0] v;
    int         n;
    wr_reg(ADDR_WRLO, 8'h0A);
    wr_reg(ADDR_WRHI, 8'h00);
    wr_reg(ADDR_WTC, 8'hC0);
    v = 8'h00;
    for (n = 0; n < 20 && v[BIT_TO] !== 1'b1; n++)
      rd_reg(ADDR_WTC, v);
    if (v[BIT_TO] !== 1'b1)
    begin
      fail("wide timeout wait ran out");
      end_of_test();
    end
    chk_byte(v, 8'h60);
    wr_reg(ADDR_WTC, 8'h40);
    rd_chk(ADDR_WTC, 8'h60);
    wr_reg(ADDR_WTC, 8'h20);
    rd_chk(ADDR_WTC, 8'h00);
    wr_reg(ADDR_WTC, 8'h80);
    rd_chk(ADDR_WTC, 8'h80);
    wr_reg(ADDR_WTC, 8'h00);
    rd_chk(ADDR_WTC, 8'h00);
  endtask
  task automatic t_demod;
    wr_reg(ADDR_SHR, 8'hA0);
    wr_reg(ADDR_NTC, 8'h84);
    cycles(4);
    wr_reg(ADDR_SHR, 8'hA3);
    rd_chk(ADDR_SHR, 8'hA0);
    rx(1'b0);
    wait_pulse(1'b1, 20);
    rd_chk(ADDR_SHR, 8'hA1);
    rx(1'b1);
    wait_pulse(1'b1, 20);
    rd_chk(ADDR_SHR, 8'hA3);
    wr_reg(ADDR_SHR, 8'hA1);
    rd_chk(ADDR_SHR, 8'hA2);
    wr_reg(ADDR_NTC, 8'h04);
    wr_reg(ADDR_SHR, 8'h00);
    rx_alt  <= 1'b1;
    rx_slow <= 1'b1;
    wr_reg(ADDR_SHR, 8'hC4);
    wr_reg(ADDR_NTC, 8'h84);
    cycles(12);
    wr_reg(ADDR_SHR, 8'hC7);
    rd_chk(ADDR_SHR, 8'hC4);
    rx(1'b0);
    rx(1'b0);
    rx(1'b1);
    cycles(14);
    rd_chk(ADDR_SHR, 8'hC4);
    rx(1'b0);
    wait_pulse(1'b1, 30);
    rx(1'b1);
    cycles(14);
    rd_chk(ADDR_SHR, 8'hC5);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_narrow();
    t_route();
    t_combine();
    t_wide();
    t_demod();
    end_of_test();
  end
endmodule
